// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // ************************************************************
   // Stimulus and checks
   // ************************************************************
   logic        clk_sys, rst, ce, reg_wr, reg_rd, pin2, pin3, pin4, pin5;
   logic [1:0]  wide_mode;
   logic [15:0] reg_addr, d;
   logic [7:0]  reg_wdata, reg_rdata;
   int          fail_count, compares, cyc;

   wgp_top u_wgp_top (.clk_sys(clk_sys), .rst(rst), .ce(ce), .wide_mode(wide_mode),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .general_pin_two(pin2), .general_pin_three(pin3),
      .general_pin_four(pin4), .general_pin_five(pin5));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // The whole sequence needs about sixteen hundred cycles; four thousand means a hang.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic end_of_test;
      if (fail_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [15:0] a);
      reg_rd = 1'b1;
      reg_addr = a;
      tick(1);
      reg_rd = 1'b0;
      d = {8'h00, reg_rdata};
      tick(1);
   endtask
   task automatic wait_pin2;
      for (int i = 0; i < 20 && !pin2; i++) tick(1);
   endtask

   task automatic t_reset;
      for (int a = 16'h108C; a <= 16'h109E; a++) begin
         rd(16'(a));
         chk("reset value", d, 16'h0000);
      end
   endtask
   task automatic t_rw;
      for (int a = 16'h1090; a <= 16'h109D; a++) if (a < 16'h1096 || a > 16'h1097) begin
         wr(16'(a), 8'(a) ^ 8'hA5);
         rd(16'(a));
         chk("readback", d, {8'h00, 8'(a) ^ 8'hA5});
         wr(16'(a), 8'h00);
      end
   endtask
   task automatic t_pair45;
      int r4 = 0, r5 = 0, m4 = 0, m5 = 0;
      wr(16'h1099, 8'h30);
      for (int i = 0; i < 150; i++) begin
         r4 = pin4 ? r4 + 1 : 0;
         r5 = pin5 ? r5 + 1 : 0;
         m4 = r4 > m4 ? r4 : m4;
         m5 = r5 > m5 ? r5 : m5;
         tick(1);
      end
      // Subperiod five and the next subperiod one are both high, so they merge.
      chk("pin4 high run", 16'(m4), 16'h0031);
      chk("pin5 high run", 16'(m5), 16'h0002);
      wide_mode = 2'b10;
      wr(16'h1098, 8'h01);
      m4 = 0;
      r4 = 0;
      for (int i = 0; i < 650; i++) begin
         r4 = pin4 ? r4 + 1 : 0;
         m4 = r4 > m4 ? r4 : m4;
         tick(1);
      end
      chk("pin4 wide run", 16'(m4), 16'h0131);
      wr(16'h1098, 8'h00);
      wide_mode = 2'b00;
   endtask
   task automatic t_odd;
      wr(16'h1090, 8'h03);
      wr(16'h1096, 8'h02);
      for (int i = 13; i >= 0; i--) begin
         chk("pin3 wave", 16'(pin3), 16'(14'h2EDD >> i) & 16'h0001);
         tick(1);
      end
      chk("pin3 stopped", 16'(pin3), 16'h0000);
      chk("pin2 untouched", 16'(pin2), 16'h0000);
      wr(16'h1096, 8'h05);
      rd(16'h1096);
      chk("pin3 count", d, 16'h0005);
      tick(6);
      rd(16'h1096);
      chk("pin3 count", d, 16'h0004);
      tick(30);
      chk("pin3 done", 16'(pin3), 16'h0000);
      wr(16'h1090, 8'h00);
   endtask
   task automatic t_finite;
      wr(16'h1097, 8'h02);
      wait_pin2();
      for (int i = 9; i >= 0; i--) begin
         chk("pin2 wave", 16'(pin2), 16'(10'h2B5 >> i) & 16'h0001);
         tick(1);
      end
      chk("pin2 stopped", 16'(pin2), 16'h0000);
      chk("pin3 unstarted", 16'(pin3), 16'h0000);
   endtask
   task automatic t_remain;
      wr(16'h1091, 8'h14);
      wr(16'h1097, 8'h03);
      tick(4);
      rd(16'h1097);
      chk("remaining", d, 16'h0003);
      tick(24);
      rd(16'h1097);
      chk("remaining", d, 16'h0002);
      tick(60);
      rd(16'h1097);
      chk("remaining", d, 16'h0000);
      chk("pin2 idle", 16'(pin2), 16'h0000);
      wr(16'h1091, 8'h00);
   endtask
   task automatic t_infinite;
      int n = 0;
      wr(16'h1097, 8'h00);
      tick(200);
      ce = 1'b0;
      tick(3);
      ce = 1'b1;
      for (int i = 0; i < 10; i++) begin
         n += pin2;
         tick(1);
      end
      chk("endless highs", 16'(n), 16'h0006);
      rd(16'h1097);
      chk("endless count", d, 16'h0000);
   endtask
   task automatic t_wide;
      int n = 0;
      wr(16'h1097, 8'h01);
      tick(10);
      wide_mode = 2'b01;
      wr(16'h108C, 8'h01);
      wr(16'h1096, 8'h01);
      wr(16'h1097, 8'h00);
      wait_pin2();
      while (pin2 === 1'b1 && n < 300) begin
         n++;
         tick(1);
      end
      chk("wide sub1 length", 16'(n), 16'h0100);
      chk("pin3 in wide", 16'(pin3), 16'h0000);
      rd(16'h1096);
      chk("count high", d, 16'h0001);
      tick(5);
      // The live low byte is now FF; the latched byte must still read 00.
      rd(16'h1097);
      chk("count low latched", d, 16'h0000);
      rd(16'h1096);
      chk("count high", d, 16'h0000);
      rd(16'h1097);
      chk("count low", d, 16'h00FF);
   endtask

   initial begin
      {rst, ce, wide_mode, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 28'h0};
      fail_count = 0;
      compares = 0;
      cyc = 0;
      repeat (5) @(posedge clk_sys);
      #1 rst = 1'b0;
      t_reset();
      t_rw();
      t_pair45();
      t_finite();
      t_remain();
      t_odd();
      t_infinite();
      t_wide();
      end_of_test();
   end
endmodule
`default_nettype wire

// ---- bench/wgp_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module wgp_checker (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic [1:0]  wide_mode,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        general_pin_two,
   input wire logic        general_pin_three,
   input wire logic        general_pin_four,
   input wire logic        general_pin_five
);
   // ************************************************************
   // Port relations
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic wr_en = reg_wr && ce;
   wire logic rd_en = reg_rd && ce;

   unmapped_read_a: assert property (rd_en && reg_addr > 16'h109D |=> reg_rdata == 8'h00)
      else $error("unmapped read returned data");
   rdata_hold_a: assert property (!rd_en |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   sub_readback_a: assert property (wr_en && reg_addr == 16'h1090 ##1 !reg_wr ##1 rd_en
      && !reg_wr && reg_addr == 16'h1090 |=> reg_rdata == $past(reg_wdata, 3))
      else $error("subperiod register read back wrong");
   start_latency_a: assert property (wr_en && reg_addr == 16'h1097 ##1 ce [*2]
      |-> ##[0:1] general_pin_two)
      else $error("waveform did not start after count write");
   wide_odd_low_a: assert property (wide_mode[0] && !general_pin_three |=> !general_pin_three)
      else $error("odd pin moved in wide mode");
   ce_freeze_a: assert property (!ce |=> $stable(general_pin_two) && $stable(general_pin_four))
      else $error("pins moved while clock enable low");
   reset_idle_a: assert property ($fell(rst) |-> reg_rdata == 8'h00
      && !general_pin_two && !general_pin_three)
      else $error("state not cleared by reset");
   pair45_runs_a: assert property ($fell(general_pin_four) && !wide_mode[1]
      |-> ##[1:256] general_pin_four)
      else $error("pin four stalled low");
endmodule
bind wgp_top wgp_checker u_wgp_checker (.clk_sys(clk_sys), .rst(rst), .ce(ce),
   .wide_mode(wide_mode), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .general_pin_two(general_pin_two),
   .general_pin_three(general_pin_three), .general_pin_four(general_pin_four),
   .general_pin_five(general_pin_five));
`default_nettype wire

// ---- common/wgp_chan_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface wgp_chan_if;
   logic [15:0] sub_len [wgp_pkg::N_SUB];
   logic [15:0] period_n;
   logic        start;
   logic [15:0] remaining;
   logic        level;
   logic        active;

   modport gen (
      input  sub_len,
      input  period_n,
      input  start,
      output remaining,
      output level,
      output active
   );
   modport ctl (
      output sub_len,
      output period_n,
      output start,
      input  remaining,
      input  level,
      input  active
   );
endinterface
`default_nettype wire

// ---- common/wgp_pkg.sv ----
`default_nettype none
package wgp_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [15:0] ADDR_PIN3_FIRST_SUB_OR_PIN2_HIGH    = 16'h108C;
   localparam logic [15:0] ADDR_PIN2_FIRST_SUB_LOW             = 16'h108D;
   localparam logic [15:0] ADDR_PIN3_SECOND_SUB_OR_PIN2_HIGH   = 16'h108E;
   localparam logic [15:0] ADDR_PIN2_SECOND_SUB_LOW            = 16'h108F;
   localparam logic [15:0] ADDR_PIN3_THIRD_SUB_OR_PIN2_HIGH    = 16'h1090;
   localparam logic [15:0] ADDR_PIN2_THIRD_SUB_LOW             = 16'h1091;
   localparam logic [15:0] ADDR_PIN3_FOURTH_SUB_OR_PIN2_HIGH   = 16'h1092;
   localparam logic [15:0] ADDR_PIN2_FOURTH_SUB_LOW            = 16'h1093;
   localparam logic [15:0] ADDR_PIN3_FIFTH_SUB_OR_PIN2_HIGH    = 16'h1094;
   localparam logic [15:0] ADDR_PIN2_FIFTH_SUB_LOW             = 16'h1095;
   localparam logic [15:0] ADDR_PIN3_PERIOD_COUNT_OR_PIN2_HIGH = 16'h1096;
   localparam logic [15:0] ADDR_PIN2_PERIOD_COUNT_LOW          = 16'h1097;
   localparam logic [15:0] ADDR_PIN5_FIRST_SUB_OR_PIN4_HIGH    = 16'h1098;
   localparam logic [15:0] ADDR_PIN4_FIRST_SUB_LOW             = 16'h1099;
   localparam logic [15:0] ADDR_PIN5_SECOND_SUB_OR_PIN4_HIGH   = 16'h109A;
   localparam logic [15:0] ADDR_PIN4_SECOND_SUB_LOW            = 16'h109B;
   localparam logic [15:0] ADDR_PIN5_THIRD_SUB_OR_PIN4_HIGH    = 16'h109C;
   localparam logic [15:0] ADDR_PIN4_THIRD_SUB_LOW             = 16'h109D;

   // ************************************************************
   // Storage layout, reset values and counts
   // ************************************************************
   localparam logic [15:0] REG_FIRST    = ADDR_PIN3_FIRST_SUB_OR_PIN2_HIGH;
   localparam logic [15:0] REG_LAST     = ADDR_PIN4_THIRD_SUB_LOW;
   localparam int          N_REGS       = 18;
   localparam int          N_SUB        = 5;
   localparam int          N_CHAN       = 4;
   localparam int          PAIR_STRIDE  = 12;
   localparam int          PAIR45_SUBS  = 3;
   localparam int          DUR_HI_IDX   = 10;
   localparam int          DUR_LO_IDX   = 11;
   localparam logic [7:0]  REG_RESET    = 8'h00;
   localparam logic [15:0] CNT_INFINITE = 16'h0000;
   localparam logic [15:0] MIN_SUB_LEN  = 16'h0001;
   localparam logic [2:0]  LAST_SUB     = 3'h4;

   typedef enum logic [0:0] {
      WGP_IDLE = 1'b0,
      WGP_RUN  = 1'b1
   } wgp_state_t;
endpackage
`default_nettype wire

// ---- logic/wgp_chan_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
module wgp_chan_gen (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic ce,
   wgp_chan_if.gen   ch
);
   wgp_pkg::wgp_state_t state_q, state_d;
   logic [2:0]          idx_q, idx_d;
   logic [15:0]         cnt_q, cnt_d;
   logic [15:0]         rem_q, rem_d;
   logic                inf_q, inf_d;
   logic                level_q;
   wire logic [15:0]    cur_len;
   wire logic [15:0]    eff_len;
   wire logic           last_tick;
   wire logic           level_d;

   // A zero length still costs one cycle, so an all-zero setup cannot stall the loop.
   assign cur_len   = ch.sub_len[idx_q];  // [R3]
   assign eff_len   = (cur_len == 16'h0000) ? wgp_pkg::MIN_SUB_LEN : cur_len;
   assign last_tick = (cnt_q >= eff_len - wgp_pkg::MIN_SUB_LEN);

   always_comb begin
      state_d = state_q;
      idx_d   = idx_q;
      cnt_d   = cnt_q;
      rem_d   = rem_q;
      inf_d   = inf_q;
      if (ch.start) begin
         state_d = wgp_pkg::WGP_RUN;
         idx_d   = 3'h0;
         cnt_d   = 16'h0000;
         rem_d   = ch.period_n;  // [R4]
         inf_d   = (ch.period_n == wgp_pkg::CNT_INFINITE);  // [R5]
      end else begin
         case (state_q)
            wgp_pkg::WGP_IDLE: begin
               state_d = wgp_pkg::WGP_IDLE;
            end
            wgp_pkg::WGP_RUN: begin
               if (last_tick) begin
                  cnt_d = 16'h0000;
                  if (idx_q == wgp_pkg::LAST_SUB) begin
                     idx_d = 3'h0;
                     if (!inf_q) begin
                        rem_d = rem_q - 16'h0001;  // [R6]
                        if (rem_q == 16'h0001) begin
                           state_d = wgp_pkg::WGP_IDLE;  // [R10]
                        end
                     end
                  end else begin
                     idx_d = idx_q + 3'h1;
                  end
               end else begin
                  cnt_d = cnt_q + 16'h0001;
               end
            end
            default: begin
               state_d = wgp_pkg::WGP_IDLE;
            end
         endcase
      end
   end

   // The pin is high in subperiods one, three and five and low when stopped.
   assign level_d = (state_d == wgp_pkg::WGP_RUN) && !idx_d[0];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= wgp_pkg::WGP_IDLE;
         idx_q   <= 3'h0;
         cnt_q   <= 16'h0000;
         rem_q   <= 16'h0000;
         inf_q   <= 1'b0;
         level_q <= 1'b0;
      end else if (ce) begin
         state_q <= state_d;
         idx_q   <= idx_d;
         cnt_q   <= cnt_d;
         rem_q   <= rem_d;
         inf_q   <= inf_d;
         level_q <= level_d;
      end
   end

   assign ch.remaining = rem_q;
   assign ch.level     = level_q;
   assign ch.active    = (state_q == wgp_pkg::WGP_RUN);
endmodule
`default_nettype wire

// ---- logic/wgp_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: 8-bit mode: each pin own byte-wide waveform
// R2: 16-bit mode: even pin uses odd:even bytes
// R3: Each period has five programmed subperiods; pins 4/5 program only three here, the last two always take one cycle
// R4: Nonzero duration write sets period count
// R5: Zero duration repeats the waveform forever
// R6: Duration read returns periods still remaining
// R7: 16-bit mode count is odd:even duration bytes
// R8: Software reads upper count byte before lower
// R9: Pin 4/5 subperiods sit at 1098..109D
// R10: Finite run stops; upper read latches lower
module wgp_top (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic [1:0] wide_mode,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            general_pin_two,
   output logic            general_pin_three,
   output logic            general_pin_four,
   output logic            general_pin_five
);
   // ************************************************************
   // Register storage and decode
   // ************************************************************
   logic [7:0]       regs_q [wgp_pkg::N_REGS];
   logic [7:0]       shadow_q;
   logic [7:0]       rdata_q;
   logic [3:0]       start_q;
   logic             boot_q;
   wire logic [15:0] rel_addr;
   wire logic [4:0]  idx;
   wire logic        in_map;
   wire logic        hit_dur_hi;
   wire logic        hit_dur_lo;
   wire logic [15:0] rem_w [wgp_pkg::N_CHAN];
   wire logic [3:0]  level_w;
   wire logic [7:0]  rd_val;

   assign rel_addr   = reg_addr - wgp_pkg::REG_FIRST;
   assign idx        = rel_addr[4:0];
   assign in_map     = (reg_addr >= wgp_pkg::REG_FIRST) && (reg_addr <= wgp_pkg::REG_LAST);  // [R9]
   assign hit_dur_hi = (reg_addr == wgp_pkg::ADDR_PIN3_PERIOD_COUNT_OR_PIN2_HIGH);
   assign hit_dur_lo = (reg_addr == wgp_pkg::ADDR_PIN2_PERIOD_COUNT_LOW);

   // Count registers read back the remaining count, live or (16-bit lower byte) latched, not the written value.
   assign rd_val = !in_map    ? 8'h00 :
                   hit_dur_hi ? (wide_mode[0] ? rem_w[0][15:8] : rem_w[1][7:0]) :  // [R6] [R7]
                   hit_dur_lo ? (wide_mode[0] ? shadow_q : rem_w[0][7:0]) :         // [R8]
                                regs_q[idx];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < wgp_pkg::N_REGS; i++) begin
            regs_q[i] <= wgp_pkg::REG_RESET;
         end
      end else if (ce && reg_wr && in_map) begin
         regs_q[idx] <= reg_wdata;
      end
   end

   // In 16-bit mode the lower byte is frozen when the upper one is read, so a carry between reads is hidden.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         shadow_q <= wgp_pkg::REG_RESET;
         rdata_q  <= wgp_pkg::REG_RESET;
      end else if (ce && reg_rd) begin
         rdata_q <= rd_val;
         if (hit_dur_hi && wide_mode[0]) begin
            shadow_q <= rem_w[0][7:0];  // [R10]
         end
      end
   end

   // ************************************************************
   // Start pulses
   // ************************************************************
   // Starts lag the write by a cycle so the generator loads the freshly stored count.
   // In 16-bit mode writing the upper byte only stores it; the lower byte write starts.
   // Pair 4/5 has no count register here and free-runs from the first cycle after reset; pin 5 starts only if wide_mode[1] is clear then.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         start_q <= 4'h0;
         boot_q  <= 1'b0;
      end else if (ce) begin
         boot_q     <= 1'b1;
         start_q[0] <= reg_wr && hit_dur_lo;                    // [R4]
         start_q[1] <= reg_wr && hit_dur_hi && !wide_mode[0];  // [R1]
         start_q[2] <= !boot_q;
         start_q[3] <= !boot_q && !wide_mode[1];
      end
   end

   // ************************************************************
   // Channels
   // ************************************************************
   for (genvar c = 0; c < wgp_pkg::N_CHAN; c++) begin : g_chan
      localparam int PAIR = c / 2;
      localparam int ODD  = c % 2;
      localparam int BASE = PAIR * wgp_pkg::PAIR_STRIDE;

      wgp_chan_if u_if ();

      for (genvar k = 0; k < wgp_pkg::N_SUB; k++) begin : g_sub
         if (PAIR == 1 && k >= wgp_pkg::PAIR45_SUBS) begin : g_none
            assign u_if.sub_len[k] = 16'h0000;
         end else if (ODD == 1) begin : g_odd
            assign u_if.sub_len[k] = {8'h00, regs_q[BASE + 2 * k]};  // [R1]
         end else begin : g_even
            assign u_if.sub_len[k] = wide_mode[PAIR] ?
                                     {regs_q[BASE + 2 * k], regs_q[BASE + 2 * k + 1]} :  // [R2]
                                     {8'h00, regs_q[BASE + 2 * k + 1]};                  // [R1]
         end
      end

      if (PAIR == 1) begin : g_count_none
         assign u_if.period_n = wgp_pkg::CNT_INFINITE;  // [R5]
      end else if (ODD == 1) begin : g_count_odd
         assign u_if.period_n = {8'h00, regs_q[wgp_pkg::DUR_HI_IDX]};
      end else begin : g_count_even
         assign u_if.period_n = wide_mode[0] ?
                                {regs_q[wgp_pkg::DUR_HI_IDX], regs_q[wgp_pkg::DUR_LO_IDX]} :  // [R7]
                                {8'h00, regs_q[wgp_pkg::DUR_LO_IDX]};
      end

      assign u_if.start = start_q[c];
      assign rem_w[c]   = u_if.remaining;
      assign level_w[c] = u_if.level;

      wgp_chan_gen u_gen (
         .clk_sys (clk_sys),
         .rst     (rst),
         .ce      (ce),
         .ch      (u_if.gen)
      );
   end

   assign reg_rdata         = rdata_q;
   assign general_pin_two   = level_w[0];
   assign general_pin_three = level_w[1];
   assign general_pin_four  = level_w[2];
   assign general_pin_five  = level_w[3];
endmodule
`default_nettype wire
